// File: src/dud_defs.svh
// Constants for the dual serial controller register decode block
`ifndef DUD_DEFS_SVH
`define DUD_DEFS_SVH

// ==========================================
// Locations
`define DUD_LOC_MODE_A     4'h0
`define DUD_LOC_STAT_A     4'h1
`define DUD_LOC_MASKED_INTERRUPT_STATUS_CMD_A 4'h2
`define DUD_LOC_HOLD_A     4'h3
`define DUD_LOC_IPC_AUX    4'h4
`define DUD_LOC_IST_IMSK   4'h5
`define DUD_LOC_TMR_UP     4'h6
`define DUD_LOC_TMR_LO     4'h7
`define DUD_LOC_MODE_B     4'h8
`define DUD_LOC_STAT_B     4'h9
`define DUD_LOC_CMD_B      4'ha
`define DUD_LOC_HOLD_B     4'hb
`define DUD_LOC_VECTOR     4'hc
`define DUD_LOC_PORT       4'hd
`define DUD_LOC_CMD_SET    4'he
`define DUD_LOC_CMD_CLR    4'hf
`define DUD_CHAN_BIT       3

// ==========================================
// Command fields and codes
`define DUD_CMD_TX_LSB     0
`define DUD_CMD_RX_LSB     2
`define DUD_CMD_MISC_LSB   4
`define DUD_EN_NONE        2'h0
`define DUD_EN_ON          2'h1
`define DUD_EN_OFF         2'h2
`define DUD_MISC_PTR_RST   4'h1
`define DUD_MISC_RX_RST    4'h2
`define DUD_MISC_TX_RST    4'h3

// ==========================================
// Reset values
`define DUD_RST_BYTE       8'h00
`define DUD_RST_OUTPORT    8'h00

`endif

// File: src/dud_pkg.sv
// Types for the dual serial controller register decode block
`default_nettype none
package dud_pkg;
    typedef enum logic [1:0] {
        DUD_ACC_IDLE,
        DUD_ACC_READ,
        DUD_ACC_WRITE
    } dud_acc_t;
endpackage
`default_nettype wire

// File: src/dud_regdec.sv
// Register decode, mode pointers and command decode for two serial channels
`default_nettype none
`include "dud_defs.svh"

module dud_regdec
    import dud_pkg::*;
(
    // Clock and reset
    input  wire logic       MCLK,
    input  wire logic       RESET,
    input  wire logic       CLK_EN,
    // Host bus pins
    input  wire logic [3:0] ADDR,
    input  wire logic       CS_N,
    input  wire logic       RD_N,
    input  wire logic       WR_N,
    input  wire logic [7:0] DIN,
    output logic      [7:0] DOUT,
    output logic            DOUT_OE_N,
    // State fed in from the channels and shared logic
    input  wire logic [7:0] STATUS_A,
    input  wire logic [7:0] STATUS_B,
    input  wire logic [7:0] RX_HOLD_A,
    input  wire logic [7:0] RX_HOLD_B,
    input  wire logic [7:0] MASKED_IRQ_STATUS,
    input  wire logic [7:0] IRQ_STATUS,
    input  wire logic [7:0] INPUT_CHANGE,
    input  wire logic [7:0] TIMER_VALUE_UP,
    input  wire logic [7:0] TIMER_VALUE_LO,
    input  wire logic [7:0] INPUT_PORT_LEVELS,
    // Stored registers
    output logic      [7:0] MODE1_A,
    output logic      [7:0] MODE2_A,
    output logic      [7:0] MODE1_B,
    output logic      [7:0] MODE2_B,
    output logic      [7:0] CLK_SEL_A,
    output logic      [7:0] CLK_SEL_B,
    output logic      [7:0] AUX_CTRL,
    output logic      [7:0] IRQ_MASK,
    output logic      [7:0] TIMER_UP,
    output logic      [7:0] TIMER_LO,
    output logic      [7:0] IRQ_VECTOR,
    output logic      [7:0] OUT_PORT_CFG,
    output logic      [7:0] GENERAL_OUTPUTS,
    output logic            MODE_PTR_A,
    output logic            MODE_PTR_B,
    // Channel control
    output logic            TX_EN_A,
    output logic            TX_EN_B,
    output logic            RX_EN_A,
    output logic            RX_EN_B,
    output logic            RX_RST_A,
    output logic            RX_RST_B,
    output logic            TX_RST_A,
    output logic            TX_RST_B,
    output logic      [3:0] MISC_CMD_A,
    output logic      [3:0] MISC_CMD_B,
    output logic            MISC_STB_A,
    output logic            MISC_STB_B,
    // One-cycle strobes, and the transmit data byte held from the last write
    output logic            TX_LOAD_A,
    output logic            TX_LOAD_B,
    output logic      [7:0] TX_DATA,
    output logic            RX_POP_A,
    output logic            RX_POP_B,
    output logic            TIMER_START,
    output logic            TIMER_STOP,
    output logic            TIMER_UP_WR,
    output logic            TIMER_LO_WR
);

    // ==========================================
    // Pin synchronisers: three stages, change accepted when stages two and three agree
    logic [2:0] cs_s_r, rd_s_r, wr_s_r;
    logic       cs_q_r, rd_q_r, wr_q_r;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            cs_s_r <= 3'h7;
            rd_s_r <= 3'h7;
            wr_s_r <= 3'h7;
            cs_q_r <= 1'b1;
            rd_q_r <= 1'b1;
            wr_q_r <= 1'b1;
        end else if (CLK_EN) begin
            cs_s_r <= {cs_s_r[1:0], CS_N};
            rd_s_r <= {rd_s_r[1:0], RD_N};
            wr_s_r <= {wr_s_r[1:0], WR_N};
            if (cs_s_r[1] == cs_s_r[2]) cs_q_r <= cs_s_r[2];
            if (rd_s_r[1] == rd_s_r[2]) rd_q_r <= rd_s_r[2];
            if (wr_s_r[1] == wr_s_r[2]) wr_q_r <= wr_s_r[2];
        end
    end

    // ==========================================
    // Access detection: one action per strobe, taken at its leading edge
    dud_acc_t acc_r, acc_nxt;
    logic     rd_act, wr_act;
    logic     rd_prev_r, wr_prev_r;

    assign rd_act = !cs_q_r && !rd_q_r;
    assign wr_act = !cs_q_r && !wr_q_r;

    always_comb begin
        acc_nxt = DUD_ACC_IDLE;
        if (rd_act && !rd_prev_r && !wr_act)
            acc_nxt = DUD_ACC_READ;
        else if (wr_act && !wr_prev_r && !rd_act)
            acc_nxt = DUD_ACC_WRITE;
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            acc_r     <= DUD_ACC_IDLE;
        end else if (CLK_EN) begin
            rd_prev_r <= rd_act;
            wr_prev_r <= wr_act;
            acc_r     <= acc_nxt;
        end
    end

    // Address and data are stable while strobes are held, so they are sampled raw
    logic rd_go, wr_go;
    assign rd_go = (acc_nxt == DUD_ACC_READ);
    assign wr_go = (acc_nxt == DUD_ACC_WRITE);

    function automatic logic hit(input logic [3:0] a, input logic [3:0] loc);
        hit = (a == loc);
    endfunction

    // ==========================================
    // Read data mux
    logic [7:0] rd_data;

    always_comb begin
        rd_data = 8'h00;
        case (ADDR)
            `DUD_LOC_MODE_A:     rd_data = MODE_PTR_A ? MODE2_A : MODE1_A;
            `DUD_LOC_STAT_A:     rd_data = STATUS_A;
            `DUD_LOC_MASKED_INTERRUPT_STATUS_CMD_A: rd_data = MASKED_IRQ_STATUS;
            `DUD_LOC_HOLD_A:     rd_data = RX_HOLD_A;
            `DUD_LOC_IPC_AUX:    rd_data = INPUT_CHANGE;
            `DUD_LOC_IST_IMSK:   rd_data = IRQ_STATUS;
            `DUD_LOC_TMR_UP:     rd_data = TIMER_VALUE_UP;
            `DUD_LOC_TMR_LO:     rd_data = TIMER_VALUE_LO;
            `DUD_LOC_MODE_B:     rd_data = MODE_PTR_B ? MODE2_B : MODE1_B;
            `DUD_LOC_STAT_B:     rd_data = STATUS_B;
            `DUD_LOC_CMD_B:      rd_data = 8'h00;
            `DUD_LOC_HOLD_B:     rd_data = RX_HOLD_B;
            `DUD_LOC_VECTOR:     rd_data = IRQ_VECTOR;
            `DUD_LOC_PORT:       rd_data = INPUT_PORT_LEVELS;
            default:             rd_data = 8'h00;
        endcase
    end

    // Data is captured at the start of the read and held until the strobe ends
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            DOUT      <= 8'h00;
            DOUT_OE_N <= 1'b1;
        end else if (CLK_EN) begin
            if (rd_go)
                DOUT <= rd_data;
            DOUT_OE_N <= !(rd_go || (rd_act && rd_prev_r && !DOUT_OE_N));
        end
    end

    // ==========================================
    // Mode pointers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            MODE_PTR_A <= 1'b0;
            MODE_PTR_B <= 1'b0;
        end else if (CLK_EN) begin
            if (wr_go && hit(ADDR, `DUD_LOC_MASKED_INTERRUPT_STATUS_CMD_A)
                && DIN[7:4] == `DUD_MISC_PTR_RST)
                MODE_PTR_A <= 1'b0;
            else if ((rd_go || wr_go) && hit(ADDR, `DUD_LOC_MODE_A))
                MODE_PTR_A <= 1'b1;
            if (wr_go && hit(ADDR, `DUD_LOC_CMD_B)
                && DIN[7:4] == `DUD_MISC_PTR_RST)
                MODE_PTR_B <= 1'b0;
            else if ((rd_go || wr_go) && hit(ADDR, `DUD_LOC_MODE_B))
                MODE_PTR_B <= 1'b1;
        end
    end

    // ==========================================
    // Stored write registers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            MODE1_A      <= `DUD_RST_BYTE;
            MODE2_A      <= `DUD_RST_BYTE;
            MODE1_B      <= `DUD_RST_BYTE;
            MODE2_B      <= `DUD_RST_BYTE;
            CLK_SEL_A    <= `DUD_RST_BYTE;
            CLK_SEL_B    <= `DUD_RST_BYTE;
            AUX_CTRL     <= `DUD_RST_BYTE;
            IRQ_MASK     <= `DUD_RST_BYTE;
            TIMER_UP     <= `DUD_RST_BYTE;
            TIMER_LO     <= `DUD_RST_BYTE;
            IRQ_VECTOR   <= `DUD_RST_BYTE;
            OUT_PORT_CFG <= `DUD_RST_BYTE;
        end else if (CLK_EN && wr_go) begin
            case (ADDR)
                `DUD_LOC_MODE_A:   if (MODE_PTR_A) MODE2_A <= DIN; else MODE1_A <= DIN;
                `DUD_LOC_STAT_A:   CLK_SEL_A <= DIN;
                `DUD_LOC_IPC_AUX:  AUX_CTRL <= DIN;
                `DUD_LOC_IST_IMSK: IRQ_MASK <= DIN;
                `DUD_LOC_TMR_UP:   TIMER_UP <= DIN;
                `DUD_LOC_TMR_LO:   TIMER_LO <= DIN;
                `DUD_LOC_MODE_B:   if (MODE_PTR_B) MODE2_B <= DIN; else MODE1_B <= DIN;
                `DUD_LOC_STAT_B:   CLK_SEL_B <= DIN;
                `DUD_LOC_VECTOR:   IRQ_VECTOR <= DIN;
                `DUD_LOC_PORT:     OUT_PORT_CFG <= DIN;
                default: ;
            endcase
        end
    end

    // ==========================================
    // Output port bits: write 1s set or clear, other bits keep
    always_ff @(posedge MCLK) begin
        if (RESET)
            GENERAL_OUTPUTS <= `DUD_RST_OUTPORT;
        else if (CLK_EN && wr_go) begin
            if (hit(ADDR, `DUD_LOC_CMD_SET))
                GENERAL_OUTPUTS <= GENERAL_OUTPUTS | DIN;
            else if (hit(ADDR, `DUD_LOC_CMD_CLR))
                GENERAL_OUTPUTS <= GENERAL_OUTPUTS & ~DIN;
        end
    end

    // ==========================================
    // Channel command decode
    function automatic logic en_next(input logic cur, input logic [1:0] code);
        case (code)
            `DUD_EN_ON:  en_next = 1'b1;
            `DUD_EN_OFF: en_next = 1'b0;
            default:     en_next = cur; // 11 is forbidden to the host, treated as no change
        endcase
    endfunction

    logic cmd_a, cmd_b;
    logic [3:0] misc;
    assign cmd_a = wr_go && hit(ADDR, `DUD_LOC_MASKED_INTERRUPT_STATUS_CMD_A);
    assign cmd_b = wr_go && hit(ADDR, `DUD_LOC_CMD_B);
    assign misc  = DIN[`DUD_CMD_MISC_LSB +: 4];

    // Reset commands win over an enable in the same write
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            TX_EN_A <= 1'b0;
            RX_EN_A <= 1'b0;
            TX_EN_B <= 1'b0;
            RX_EN_B <= 1'b0;
        end else if (CLK_EN) begin
            if (cmd_a) begin
                TX_EN_A <= (misc == `DUD_MISC_TX_RST) ? 1'b0 :
                           en_next(TX_EN_A, DIN[`DUD_CMD_TX_LSB +: 2]);
                RX_EN_A <= (misc == `DUD_MISC_RX_RST) ? 1'b0 :
                           en_next(RX_EN_A, DIN[`DUD_CMD_RX_LSB +: 2]);
            end
            if (cmd_b) begin
                TX_EN_B <= (misc == `DUD_MISC_TX_RST) ? 1'b0 :
                           en_next(TX_EN_B, DIN[`DUD_CMD_TX_LSB +: 2]);
                RX_EN_B <= (misc == `DUD_MISC_RX_RST) ? 1'b0 :
                           en_next(RX_EN_B, DIN[`DUD_CMD_RX_LSB +: 2]);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            RX_RST_A   <= 1'b0;
            TX_RST_A   <= 1'b0;
            RX_RST_B   <= 1'b0;
            TX_RST_B   <= 1'b0;
            MISC_CMD_A <= 4'h0;
            MISC_CMD_B <= 4'h0;
            MISC_STB_A <= 1'b0;
            MISC_STB_B <= 1'b0;
        end else if (CLK_EN) begin
            RX_RST_A   <= cmd_a && misc == `DUD_MISC_RX_RST;
            TX_RST_A   <= cmd_a && misc == `DUD_MISC_TX_RST;
            RX_RST_B   <= cmd_b && misc == `DUD_MISC_RX_RST;
            TX_RST_B   <= cmd_b && misc == `DUD_MISC_TX_RST;
            MISC_STB_A <= cmd_a;
            MISC_STB_B <= cmd_b;
            if (cmd_a) MISC_CMD_A <= misc;
            if (cmd_b) MISC_CMD_B <= misc;
        end
    end

    // ==========================================
    // Access strobes to the channels and timer
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            TX_LOAD_A   <= 1'b0;
            TX_LOAD_B   <= 1'b0;
            TX_DATA     <= 8'h00;
            RX_POP_A    <= 1'b0;
            RX_POP_B    <= 1'b0;
            TIMER_START <= 1'b0;
            TIMER_STOP  <= 1'b0;
            TIMER_UP_WR <= 1'b0;
            TIMER_LO_WR <= 1'b0;
        end else if (CLK_EN) begin
            TX_LOAD_A   <= wr_go && hit(ADDR, `DUD_LOC_HOLD_A);
            TX_LOAD_B   <= wr_go && hit(ADDR, `DUD_LOC_HOLD_B);
            RX_POP_A    <= rd_go && hit(ADDR, `DUD_LOC_HOLD_A);
            RX_POP_B    <= rd_go && hit(ADDR, `DUD_LOC_HOLD_B);
            TIMER_START <= rd_go && hit(ADDR, `DUD_LOC_CMD_SET);
            TIMER_STOP  <= rd_go && hit(ADDR, `DUD_LOC_CMD_CLR);
            TIMER_UP_WR <= wr_go && hit(ADDR, `DUD_LOC_TMR_UP);
            TIMER_LO_WR <= wr_go && hit(ADDR, `DUD_LOC_TMR_LO);
            if (wr_go)
                TX_DATA <= DIN;
        end
    end

endmodule // dud_regdec
`default_nettype wire

// File: bench/dud_host.sv
// Host bus model driving the register decode pins
`default_nettype none
module dud_host (
    // Bus answer
    input  wire logic       MCLK,
    input  wire logic       DOUT_OE_N,
    // Bus pins
    output logic      [3:0] ADDR,
    output logic            CS_N,
    output logic            RD_N,
    output logic            WR_N,
    output logic      [7:0] DIN,
    // Read answer never came
    output logic            STUCK
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {ADDR, DIN} = 12'h000;
        {CS_N, RD_N, WR_N} = 3'h7;
        STUCK = 1'b0;
    end
    // ==========================================
    // One access, pins changed just after an edge
    task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic rd);
        int n;
        @(posedge MCLK);
        #2;
        {ADDR, DIN} = {a, d};
        {CS_N, RD_N, WR_N} = {1'b0, !rd, rd};
        n = 0;
        // Writes carry no answer, so a fixed hold
        while (n < (rd ? 12 : 6) && !(rd && DOUT_OE_N === 1'b0)) begin
            @(posedge MCLK);
            #2;
            n++;
        end
        if (rd && n == 12 && a[3:1] != 3'h7)
            STUCK = 1'b1;
        {CS_N, RD_N, WR_N} = 3'h7;
        // Released lines must not keep the last value
        {ADDR, DIN} = ~{a, d};
        repeat (7) @(posedge MCLK);
    endtask
endmodule // dud_host
`default_nettype wire

// File: bench/dud_regdec_assertions.sv
// Checker for the register decode block
`default_nettype none
module dud_regdec_assertions (
    input wire logic       MCLK,
    input wire logic       RESET,
    input wire logic [3:0] ADDR,
    input wire logic       WR_N,
    input wire logic [7:0] DIN,
    input wire logic [7:0] DOUT,
    input wire logic       DOUT_OE_N,
    input wire logic [7:0] GENERAL_OUTPUTS,
    input wire logic       MODE_PTR_A,
    input wire logic       MODE_PTR_B,
    input wire logic       TX_EN_A,
    input wire logic       TX_EN_B,
    input wire logic       RX_EN_A,
    input wire logic       RX_EN_B,
    input wire logic       TX_RST_A,
    input wire logic [3:0] MISC_CMD_A,
    input wire logic       MISC_STB_A,
    input wire logic       MISC_STB_B,
    input wire logic       TX_LOAD_A,
    input wire logic [7:0] TX_DATA
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    // ==========================================
    // Properties
    property p_rst_ptr;
        disable iff (1'b0) RESET |=> !MODE_PTR_A && !MODE_PTR_B && DOUT_OE_N;
    endproperty
    property p_ptr_hold;
        $fell(MODE_PTR_A) |-> $past(RESET) || (MISC_STB_A && MISC_CMD_A == 4'h1);
    endproperty
    property p_ptr_cmd;
        MISC_STB_A && MISC_CMD_A == 4'h1 |-> !MODE_PTR_A;
    endproperty
    property p_tx_code;
        MISC_STB_A && $past(DIN[7:4]) != 4'h3 |-> TX_EN_A == ($past(DIN[1:0]) == 2'h1 ? 1'b1 :
            $past(DIN[1:0]) == 2'h2 ? 1'b0 : $past(TX_EN_A));
    endproperty
    property p_rx_code;
        MISC_STB_A && $past(DIN[7:4]) != 4'h2 |-> RX_EN_A == ($past(DIN[3:2]) == 2'h1 ? 1'b1 :
            $past(DIN[3:2]) == 2'h2 ? 1'b0 : $past(RX_EN_A));
    endproperty
    property p_iso;
        MISC_STB_A |-> !MISC_STB_B && $stable(MODE_PTR_B) && $stable(TX_EN_B) && $stable(RX_EN_B);
    endproperty
    property p_tx_load;
        TX_LOAD_A |-> TX_DATA == $past(DIN) && $past(ADDR) == 4'h3;
    endproperty
    property p_outbits;
        $changed(GENERAL_OUTPUTS) |-> !$past(WR_N) && $past(ADDR[3:1]) == 3'h7 && GENERAL_OUTPUTS ==
            ($past(ADDR[0]) ? $past(GENERAL_OUTPUTS) & ~$past(DIN) : $past(GENERAL_OUTPUTS) | $past(DIN));
    endproperty
    property p_rsvd;
        $fell(DOUT_OE_N) && $past(ADDR) == 4'ha |-> DOUT == 8'h00;
    endproperty
    property p_tx_rst;
        TX_RST_A |-> MISC_STB_A && MISC_CMD_A == 4'h3 && !TX_EN_A;
    endproperty
    // ==========================================
    // Assertions and covers
    a_rst_ptr: assert property (p_rst_ptr) else $error("pointer or enable wrong after reset");
    a_ptr_hold: assert property (p_ptr_hold) else $error("mode pointer fell without command");
    a_ptr_cmd: assert property (p_ptr_cmd) else $error("pointer command ignored");
    a_tx_code: assert property (p_tx_code) else $error("transmit enable code wrong");
    a_rx_code: assert property (p_rx_code) else $error("receive enable code wrong");
    a_iso: assert property (p_iso) else $error("command disturbed other channel");
    a_tx_load: assert property (p_tx_load) else $error("transmit load wrong");
    a_outbits: assert property (p_outbits) else $error("output bits changed wrongly");
    a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
    a_tx_rst: assert property (p_tx_rst) else $error("transmit reset wrong");
    c_ptr: cover property (MISC_STB_A && MISC_CMD_A == 4'h1);
    c_read: cover property ($fell(DOUT_OE_N));
    c_txrst: cover property (TX_RST_A);
endmodule // dud_regdec_assertions
bind dud_regdec dud_regdec_assertions u_chk (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WR_N(WR_N),
    .DIN(DIN), .DOUT(DOUT), .DOUT_OE_N(DOUT_OE_N), .GENERAL_OUTPUTS(GENERAL_OUTPUTS),
    .MODE_PTR_A(MODE_PTR_A), .MODE_PTR_B(MODE_PTR_B), .TX_EN_A(TX_EN_A), .TX_EN_B(TX_EN_B),
    .RX_EN_A(RX_EN_A), .RX_EN_B(RX_EN_B), .TX_RST_A(TX_RST_A), .MISC_CMD_A(MISC_CMD_A),
    .MISC_STB_A(MISC_STB_A), .MISC_STB_B(MISC_STB_B), .TX_LOAD_A(TX_LOAD_A), .TX_DATA(TX_DATA));
`default_nettype wire

// File: bench/dud_regdec_tb.sv
// Self-checking bench for the register decode block
`default_nettype none
module dud_regdec_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       MCLK, RESET, CS_N, RD_N, WR_N, DOUT_OE_N, STUCK, MODE_PTR_A, MODE_PTR_B;
    logic       TX_EN_A, TX_EN_B, RX_EN_A, RX_EN_B, RX_RST_A, RX_RST_B, TX_RST_A, TX_RST_B;
    logic       TX_LOAD_A, TX_LOAD_B, RX_POP_A, RX_POP_B, TIMER_START, TIMER_STOP, TIMER_UP_WR, TIMER_LO_WR;
    logic [3:0] ADDR, MISC_CMD_A, MISC_CMD_B;
    logic [7:0] DIN, DOUT, MODE1_A, MODE2_A, MODE1_B, MODE2_B, CLK_SEL_A, CLK_SEL_B, AUX_CTRL, IRQ_MASK;
    logic [7:0] TIMER_UP, TIMER_LO, IRQ_VECTOR, OUT_PORT_CFG, GENERAL_OUTPUTS, TX_DATA, d, m1, m2, interrupt_vector;
    logic [79:0] rnd;
    logic [7:0]  exp_q[$];
    logic        ch, oe_q = 1'b1, clk_en = 1'b1;
    int          seed = 55, failures = 0, checks = 0, pc[12];
    localparam logic [7:0] CMDS [7] = '{8'h05, 8'h00, 8'h0a, 8'h09, 8'h06, 8'h21, 8'h35};
    localparam logic [1:0] TRX [7] = '{2'h3, 2'h3, 2'h0, 2'h2, 2'h1, 2'h2, 2'h1};
    dud_regdec dut (.MCLK(MCLK), .RESET(RESET), .CLK_EN(clk_en), .ADDR(ADDR), .CS_N(CS_N), .RD_N(RD_N),
        .WR_N(WR_N), .DIN(DIN), .DOUT(DOUT), .DOUT_OE_N(DOUT_OE_N), .STATUS_A(rnd[7:0]), .STATUS_B(rnd[15:8]),
        .RX_HOLD_A(rnd[23:16]), .RX_HOLD_B(rnd[31:24]), .MASKED_IRQ_STATUS(rnd[39:32]), .IRQ_STATUS(rnd[47:40]),
        .INPUT_CHANGE(rnd[55:48]), .TIMER_VALUE_UP(rnd[63:56]), .TIMER_VALUE_LO(rnd[71:64]),
        .INPUT_PORT_LEVELS(rnd[79:72]), .MODE1_A(MODE1_A), .MODE2_A(MODE2_A), .MODE1_B(MODE1_B),
        .MODE2_B(MODE2_B), .CLK_SEL_A(CLK_SEL_A), .CLK_SEL_B(CLK_SEL_B), .AUX_CTRL(AUX_CTRL), .IRQ_MASK(IRQ_MASK),
        .TIMER_UP(TIMER_UP), .TIMER_LO(TIMER_LO), .IRQ_VECTOR(IRQ_VECTOR), .OUT_PORT_CFG(OUT_PORT_CFG),
        .GENERAL_OUTPUTS(GENERAL_OUTPUTS), .MODE_PTR_A(MODE_PTR_A), .MODE_PTR_B(MODE_PTR_B), .TX_EN_A(TX_EN_A),
        .TX_EN_B(TX_EN_B), .RX_EN_A(RX_EN_A), .RX_EN_B(RX_EN_B), .RX_RST_A(RX_RST_A), .RX_RST_B(RX_RST_B),
        .TX_RST_A(TX_RST_A), .TX_RST_B(TX_RST_B), .MISC_CMD_A(MISC_CMD_A), .MISC_CMD_B(MISC_CMD_B),
        .MISC_STB_A(), .MISC_STB_B(), .TX_LOAD_A(TX_LOAD_A), .TX_LOAD_B(TX_LOAD_B), .TX_DATA(TX_DATA),
        .RX_POP_A(RX_POP_A), .RX_POP_B(RX_POP_B), .TIMER_START(TIMER_START), .TIMER_STOP(TIMER_STOP),
        .TIMER_UP_WR(TIMER_UP_WR), .TIMER_LO_WR(TIMER_LO_WR));
    dud_host host (.MCLK(MCLK), .DOUT_OE_N(DOUT_OE_N), .ADDR(ADDR), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
        .DIN(DIN), .STUCK(STUCK));
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    // ==========================================
    // Compare, verdict, read monitor
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (e !== g) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        chk("pending reads", 8'h00, 8'(exp_q.size()));
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge STUCK) begin
        failures++;
        give_verdict();
    end
    // Oldest expected byte taken where the read enable first drops
    always @(negedge MCLK) begin
        oe_q <= DOUT_OE_N;
        if (oe_q === 1'b1 && DOUT_OE_N === 1'b0 && exp_q.size() > 0)
            chk("read data", exp_q.pop_front(), DOUT);
        for (int i = 0; i < 12; i++)
            pc[i] += int'({TIMER_START, TIMER_STOP, RX_POP_A, RX_POP_B, TX_LOAD_A, TX_LOAD_B, TIMER_UP_WR,
                TIMER_LO_WR, RX_RST_A, RX_RST_B, TX_RST_A, TX_RST_B} >> i & 12'h001);
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        host.acc(a, v, 1'b0);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.acc(a, 8'h00, 1'b1);
    endtask
    function automatic logic [7:0] ptr(input logic c);
        return {7'h0, c ? MODE_PTR_B : MODE_PTR_A};
    endfunction
    function automatic logic [7:0] en(input logic c);
        return {6'h0, c ? {TX_EN_B, RX_EN_B} : {TX_EN_A, RX_EN_A}};
    endfunction
    function automatic logic [7:0] rexp(input logic [3:0] a);
        case (a)
            4'h1: return rnd[7:0];
            4'h9: return rnd[15:8];
            4'h3: return rnd[23:16];
            4'hb: return rnd[31:24];
            4'h2: return rnd[39:32];
            4'h5: return rnd[47:40];
            4'h4: return rnd[55:48];
            4'h6: return rnd[63:56];
            4'h7: return rnd[71:64];
            4'hd: return rnd[79:72];
            4'hc: return interrupt_vector;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] wval(input logic [3:0] a);
        case (a)
            4'h1: return CLK_SEL_A;
            4'h4: return AUX_CTRL;
            4'h5: return IRQ_MASK;
            4'h6: return TIMER_UP;
            4'h7: return TIMER_LO;
            4'h9: return CLK_SEL_B;
            4'hc: return IRQ_VECTOR;
            4'hd: return OUT_PORT_CFG;
            default: return TX_DATA;
        endcase
    endfunction
    // ==========================================
    // Main sequence
    initial begin
        RESET = 1'b1;
        interrupt_vector = 8'h00;
        rnd = 80'({$random(seed), $random(seed), $random(seed)});
        repeat (16) @(posedge MCLK);
        #2;
        RESET = 1'b0;
        @(posedge MCLK);
        #2;
        chk("reset levels", 8'h04, {3'h0, MODE_PTR_A, MODE_PTR_B, DOUT_OE_N, TX_EN_A, RX_EN_B});
        for (int c = 0; c < 2; c++) begin
            ch = 1'(c);
            m1 = 8'($random(seed));
            m2 = 8'($random(seed));
            wr({ch, 3'h0}, m1);
            chk("first mode", m1, ch ? MODE1_B : MODE1_A);
            chk("pointer advanced", 8'h01, ptr(ch));
            wr({ch, 3'h0}, m2);
            chk("second mode", m2, ch ? MODE2_B : MODE2_A);
            rd({ch, 3'h0}, m2);
            chk("pointer held", 8'h01, ptr(ch));
            wr(ch ? 4'ha : 4'h2, 8'h10);
            chk("pointer reset", 8'h00, ptr(ch));
            chk("other pointer", {7'h0, ch}, ptr(!ch));
            rd({ch, 3'h0}, m1);
            chk("pointer again", 8'h01, ptr(ch));
        end
        for (int a = 1; a < 14; a++)
            if (a != 8)
                rd(4'(a), rexp(4'(a)));
        host.acc(4'he, 8'h00, 1'b1);
        host.acc(4'hf, 8'h00, 1'b1);
        for (int a = 1; a < 14; a++)
            if (a inside {1, 3, 4, 5, 6, 7, 9, 11, 12, 13}) begin
                d = 8'($random(seed));
                wr(4'(a), d);
                chk("written register", d, wval(4'(a)));
                interrupt_vector = (a == 12) ? d : interrupt_vector;
            end
        rd(4'hc, interrupt_vector);
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 7; i++) begin
                ch = 1'(c);
                m1 = en(!ch);
                wr(ch ? 4'ha : 4'h2, CMDS[i]);
                chk("enables", {6'h0, TRX[i]}, en(ch));
                chk("misc code", {4'h0, CMDS[i][7:4]}, {4'h0, ch ? MISC_CMD_B : MISC_CMD_A});
                chk("other enables", m1, en(!ch));
            end
        wr(4'he, 8'hf0);
        chk("port bits", 8'hf0, GENERAL_OUTPUTS);
        wr(4'hf, 8'h30);
        chk("port bits", 8'hc0, GENERAL_OUTPUTS);
        // Whole access made while frozen must leave no trace
        wr(4'h4, 8'h3c);
        chk("aux before freeze", 8'h3c, AUX_CTRL);
        #2;
        clk_en = 1'b0;
        wr(4'h4, 8'hc3);
        chk("frozen write", 8'h3c, AUX_CTRL);
        #2;
        clk_en = 1'b1;
        wr(4'h4, 8'hc3);
        chk("resumed write", 8'hc3, AUX_CTRL);
        for (int i = 0; i < 12; i++)
            chk("pulse count", 8'h01, 8'(pc[i]));
        give_verdict();
    end
endmodule // dud_regdec_tb
`default_nettype wire
